// ### rtl/tmma_pkg.sv
// package: constants and types for the table statistics unit
// assumes a word-addressed register memory with 16-bit signed words
package tmma_pkg;
  localparam int DATA_W   = 16;             // table word width
  localparam int ADDR_W   = 16;             // register memory address width
  localparam int LEN_W    = 7;              // holds table length 1..64
  localparam int SUM_W    = 22;             // 64 x 16-bit signed sum
  localparam logic [LEN_W-1:0] LEN_MIN = 7'h01;
  localparam logic [LEN_W-1:0] LEN_MAX = 7'h40;
  localparam logic [ADDR_W-1:0] PTR_OFS = 16'h0001;  // position word follows value
  localparam int DIV_STEPS = SUM_W;         // one quotient bit per cycle
  localparam logic [DATA_W-1:0] WORD_RST = 16'h0000;

  // table operation select
  typedef enum logic [1:0] {
    TMMA_OP_MAX,
    TMMA_OP_MIN,
    TMMA_OP_MEAN
  } tmma_op_t;
endpackage : tmma_pkg

// ### rtl/tmma_div.sv
// serial signed divider: table sum by table length, quotient truncated toward zero
// assumes divisor is non-zero and quotient magnitude fits one word
`timescale 1ns/10ps
module tmma_div
  import tmma_pkg::*;
(
  // clock and reset
  input  wire logic                     clock,
  input  wire logic                     rst,
  // request
  input  wire logic                     start,
  input  wire logic signed [SUM_W-1:0]  dividend,
  input  wire logic [LEN_W-1:0]         divisor,
  // answer
  output logic signed [DATA_W-1:0]      quotient,
  output logic                          done
);
  typedef enum logic [1:0] {DV_IDLE, DV_RUN, DV_FIX} tmma_dv_t;

  tmma_dv_t         st_r, st_nxt;
  logic [SUM_W-1:0] num_r, num_nxt;     // shifts out dividend, shifts in quotient
  logic [LEN_W:0]   rem_r, rem_nxt;
  logic [4:0]       cnt_r, cnt_nxt;
  logic             neg_r, neg_nxt;
  logic [DATA_W-1:0] q_r, q_nxt;
  logic             done_r, done_nxt;
  logic [LEN_W:0]   trial;

  // restoring division on the magnitude; the sign is put back at the end
  always_comb begin
    st_nxt   = st_r;
    num_nxt  = num_r;
    rem_nxt  = rem_r;
    cnt_nxt  = cnt_r;
    neg_nxt  = neg_r;
    q_nxt    = q_r;
    done_nxt = 1'b0;
    trial    = {rem_r[LEN_W-1:0], num_r[SUM_W-1]};
    case (st_r)
      DV_IDLE: begin
        if (start) begin
          neg_nxt = dividend[SUM_W-1];
          num_nxt = dividend[SUM_W-1] ? SUM_W'(-dividend) : dividend;
          rem_nxt = '0;
          cnt_nxt = 5'(DIV_STEPS - 1);
          st_nxt  = DV_RUN;
        end
      end
      DV_RUN: begin
        if (trial >= {1'b0, divisor}) begin
          rem_nxt = trial - {1'b0, divisor};
          num_nxt = {num_r[SUM_W-2:0], 1'b1};
        end else begin
          rem_nxt = trial;
          num_nxt = {num_r[SUM_W-2:0], 1'b0};
        end
        cnt_nxt = cnt_r - 5'h01;
        if (cnt_r == 5'h00) st_nxt = DV_FIX;
      end
      DV_FIX: begin
        q_nxt    = neg_r ? DATA_W'(-num_r[DATA_W-1:0]) : num_r[DATA_W-1:0];
        done_nxt = 1'b1;
        st_nxt   = DV_IDLE;
      end
      default: st_nxt = DV_IDLE;
    endcase
  end

  // divider state registers
  always_ff @(posedge clock) begin
    if (rst) begin
      st_r   <= DV_IDLE;
      num_r  <= '0;
      rem_r  <= '0;
      cnt_r  <= '0;
      neg_r  <= 1'b0;
      q_r    <= WORD_RST;
      done_r <= 1'b0;
    end else begin
      st_r   <= st_nxt;
      num_r  <= num_nxt;
      rem_r  <= rem_nxt;
      cnt_r  <= cnt_nxt;
      neg_r  <= neg_nxt;
      q_r    <= q_nxt;
      done_r <= done_nxt;
    end
  end

  assign quotient = q_r;
  assign done     = done_r;
endmodule : tmma_div

// ### rtl/tmma_unit.sv
// table statistics unit: maximum search, minimum search and mean of a word table
// assumes a register memory on the same clock with one cycle of read latency
`timescale 1ns/10ps
module tmma_unit
  import tmma_pkg::*;
(
  // clock and reset
  input  wire logic                  clock,
  input  wire logic                  rst,
  // instruction from sequencer
  input  wire logic                  instr_on,
  input  wire tmma_pkg::tmma_op_t    op_sel,
  input  wire logic [ADDR_W-1:0]     table_start,
  input  wire logic [LEN_W-1:0]      table_len,
  input  wire logic [ADDR_W-1:0]     result_addr,
  input  wire logic                  result_is_index,
  // register memory read port
  output logic                       rd_en,
  output logic [ADDR_W-1:0]          rd_addr,
  input  wire logic [DATA_W-1:0]     rd_data,
  // register memory write port
  output logic                       wr_en,
  output logic [ADDR_W-1:0]          wr_addr,
  output logic [DATA_W-1:0]          wr_data,
  // instruction output and status
  output logic                       instr_out,
  output logic                       busy
);
  import tmma_pkg::*;

  typedef enum logic [2:0] {
    ST_IDLE, ST_READ, ST_TAKE, ST_DIV, ST_WVAL, ST_WPOS, ST_DONE
  } tmma_state_t;

  // true when the new word should replace the best so far
  function automatic logic tmma_better(input tmma_op_t op,
                                       input logic signed [DATA_W-1:0] cand,
                                       input logic signed [DATA_W-1:0] best);
    // strict compare keeps the earliest of equal extremes
    if (op == TMMA_OP_MAX) tmma_better = cand > best;
    else                   tmma_better = cand < best;
  endfunction : tmma_better

  tmma_state_t             st_r, st_nxt;
  tmma_op_t                op_r, op_nxt;
  logic [ADDR_W-1:0]       base_r, base_nxt;
  logic [LEN_W-1:0]        len_r, len_nxt;
  logic [ADDR_W-1:0]       dst_r, dst_nxt;
  logic                    kdst_r, kdst_nxt;
  logic [LEN_W-1:0]        idx_r, idx_nxt;
  logic signed [DATA_W-1:0] best_r, best_nxt;
  logic [LEN_W-1:0]        pos_r, pos_nxt;
  logic signed [SUM_W-1:0] sum_r, sum_nxt;
  logic                    div_go_r, div_go_nxt;
  logic                    rd_en_r, rd_en_nxt;
  logic [ADDR_W-1:0]       rd_addr_r, rd_addr_nxt;
  logic                    wr_en_r, wr_en_nxt;
  logic [ADDR_W-1:0]       wr_addr_r, wr_addr_nxt;
  logic [DATA_W-1:0]       wr_data_r, wr_data_nxt;
  logic                    out_r, out_nxt;
  logic                    busy_r, busy_nxt;
  logic signed [DATA_W-1:0] mean_q;
  logic                    mean_done;
  logic signed [DATA_W-1:0] word;

  tmma_div u_div (
    .clock    (clock),
    .rst      (rst),
    .start    (div_go_r),
    .dividend (sum_r),
    .divisor  (len_r),
    .quotient (mean_q),
    .done     (mean_done)
  );

  // sequencer: fetch each word, fold it in, then write the results
  always_comb begin
    st_nxt      = st_r;
    op_nxt      = op_r;
    base_nxt    = base_r;
    len_nxt     = len_r;
    dst_nxt     = dst_r;
    kdst_nxt    = kdst_r;
    idx_nxt     = idx_r;
    best_nxt    = best_r;
    pos_nxt     = pos_r;
    sum_nxt     = sum_r;
    div_go_nxt  = 1'b0;
    rd_en_nxt   = 1'b0;
    rd_addr_nxt = rd_addr_r;
    wr_en_nxt   = 1'b0;
    wr_addr_nxt = wr_addr_r;
    wr_data_nxt = wr_data_r;
    out_nxt     = out_r & instr_on;
    word        = signed'(rd_data);
    case (st_r)
      ST_IDLE: begin
        if (instr_on) begin
          op_nxt      = op_sel;
          base_nxt    = table_start;
          len_nxt     = table_len;
          dst_nxt     = result_addr;
          kdst_nxt    = result_is_index;
          idx_nxt     = '0;
          sum_nxt     = '0;
          rd_en_nxt   = 1'b1;
          rd_addr_nxt = table_start;
          st_nxt      = ST_READ;
        end
      end
      ST_READ: st_nxt = ST_TAKE;                           // memory latency
      ST_TAKE: begin
        sum_nxt = sum_r + SUM_W'(word);
        if (idx_r == '0 || tmma_better(op_r, word, best_r)) begin
          best_nxt = word;
          pos_nxt  = idx_r;
        end
        if (idx_r + 7'h01 >= len_r) begin
          if (op_r == TMMA_OP_MEAN) begin
            div_go_nxt = 1'b1;
            st_nxt     = ST_DIV;
          end else begin
            st_nxt = ST_WVAL;
          end
        end else begin
          idx_nxt     = idx_r + 7'h01;
          rd_en_nxt   = 1'b1;
          rd_addr_nxt = base_r + ADDR_W'(idx_r + 7'h01);
          st_nxt      = ST_READ;
        end
      end
      ST_DIV: begin
        if (mean_done) begin
          best_nxt = mean_q;
          st_nxt   = ST_WVAL;
        end
      end
      ST_WVAL: begin
        wr_en_nxt   = 1'b1;
        wr_addr_nxt = dst_r;
        wr_data_nxt = best_r;
        // mean has no position; index register keeps only the value
        if (op_r == TMMA_OP_MEAN || kdst_r) st_nxt = ST_DONE;
        else                                 st_nxt = ST_WPOS;
      end
      ST_WPOS: begin
        wr_en_nxt   = 1'b1;
        wr_addr_nxt = dst_r + PTR_OFS;
        wr_data_nxt = DATA_W'(pos_r);
        st_nxt      = ST_DONE;
      end
      ST_DONE: begin
        out_nxt = instr_on;
        st_nxt  = ST_IDLE;
      end
      default: st_nxt = ST_IDLE;
    endcase
    // busy follows the next state so it leaves a flop like the other outputs
    busy_nxt = (st_nxt != ST_IDLE);
  end

  // sequencer registers
  always_ff @(posedge clock) begin
    if (rst) begin
      st_r      <= ST_IDLE;
      op_r      <= TMMA_OP_MAX;
      base_r    <= '0;
      len_r     <= LEN_MIN;
      dst_r     <= '0;
      kdst_r    <= 1'b0;
      idx_r     <= '0;
      best_r    <= WORD_RST;
      pos_r     <= '0;
      sum_r     <= '0;
      div_go_r  <= 1'b0;
      rd_en_r   <= 1'b0;
      rd_addr_r <= '0;
      wr_en_r   <= 1'b0;
      wr_addr_r <= '0;
      wr_data_r <= WORD_RST;
      out_r     <= 1'b0;
      busy_r    <= 1'b0;
    end else begin
      st_r      <= st_nxt;
      op_r      <= op_nxt;
      base_r    <= base_nxt;
      len_r     <= len_nxt;
      dst_r     <= dst_nxt;
      kdst_r    <= kdst_nxt;
      idx_r     <= idx_nxt;
      best_r    <= best_nxt;
      pos_r     <= pos_nxt;
      sum_r     <= sum_nxt;
      div_go_r  <= div_go_nxt;
      rd_en_r   <= rd_en_nxt;
      rd_addr_r <= rd_addr_nxt;
      wr_en_r   <= wr_en_nxt;
      wr_addr_r <= wr_addr_nxt;
      wr_data_r <= wr_data_nxt;
      out_r     <= out_nxt;
      busy_r    <= busy_nxt;
    end
  end

  // every output straight from a flip-flop
  assign rd_en     = rd_en_r;
  assign rd_addr   = rd_addr_r;
  assign wr_en     = wr_en_r;
  assign wr_addr   = wr_addr_r;
  assign wr_data   = wr_data_r;
  assign instr_out = out_r;
  assign busy      = busy_r;
endmodule : tmma_unit

// ### tb/tmma_unit_chk.sv
// checker: port timing relations of the table statistics unit
// assumes it is bound to tmma_unit and sees only its ports
`timescale 1ns/10ps
module tmma_unit_chk
  import tmma_pkg::*;
(
  // clock, reset and request
  input wire logic                clock,
  input wire logic                rst,
  input wire logic                instr_on,
  input wire logic                result_is_index,
  input wire tmma_pkg::tmma_op_t  op_sel,
  input wire logic [ADDR_W-1:0]   table_start,
  input wire logic [LEN_W-1:0]    table_len,
  // memory side and status
  input wire logic                rd_en,
  input wire logic                wr_en,
  input wire logic                instr_out,
  input wire logic                busy,
  input wire logic [ADDR_W-1:0]   rd_addr,
  input wire logic [ADDR_W-1:0]   wr_addr,
  input wire logic [DATA_W-1:0]   wr_data
);
  import tmma_pkg::*;

  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);

  // an operation only starts when the input was on
  a_take_needs_on: assert property ($rose(busy) |-> $past(instr_on))
    else $error("busy rose without instruction input");
  // two low samples of the input leave the output off
  a_off_out_low: assert property (!instr_on ##1 !instr_on |-> !instr_out)
    else $error("output on while input off");
  a_out_needs_on: assert property ($rose(instr_out) |-> $past(instr_on))
    else $error("output rose without input");
  // position word goes to the next address and lies inside the table
  a_pos_follows: assert property (wr_en ##1 wr_en |->
    wr_addr == $past(wr_addr) + PTR_OFS && wr_data < table_len)
    else $error("position write misplaced");
  a_index_no_pos: assert property (
    wr_en && (result_is_index || op_sel == TMMA_OP_MEAN) |=> !wr_en)
    else $error("second write after single result");
  a_read_in_table: assert property (rd_en |-> rd_addr - table_start < table_len)
    else $error("read outside table");
  a_first_read: assert property (
    $rose(busy) |-> ##[0:2] (rd_en && rd_addr == table_start))
    else $error("first read not at table start");
  // longest case is the mean of 64 words
  a_done_bound: assert property ($rose(busy) |-> ##[3:170] !busy)
    else $error("operation did not finish");
endmodule : tmma_unit_chk

bind tmma_unit tmma_unit_chk i_chk (.clock(clock), .rst(rst), .instr_on(instr_on),
  .op_sel(op_sel), .table_start(table_start), .table_len(table_len),
  .result_is_index(result_is_index), .rd_en(rd_en), .rd_addr(rd_addr), .wr_en(wr_en),
  .wr_addr(wr_addr), .wr_data(wr_data), .instr_out(instr_out), .busy(busy));

// ### tb/tmma_mem.sv
// partner: word register memory with one cycle of read latency
// assumes addresses below 256; the bench preloads tables through mem
`timescale 1ns/10ps
module tmma_mem
  import tmma_pkg::*;
(
  // clock
  input  wire logic              clock,
  // read port
  input  wire logic              rd_en,
  input  wire logic [ADDR_W-1:0] rd_addr,
  output logic      [DATA_W-1:0] rd_data,
  // write port
  input  wire logic              wr_en,
  input  wire logic [ADDR_W-1:0] wr_addr,
  input  wire logic [DATA_W-1:0] wr_data
);
  logic [DATA_W-1:0] mem [0:255];
  initial rd_data = 16'h5A5A;
  // data valid one cycle only, then inverted so a late sample is caught
  always @(posedge clock) begin
    rd_data <= rd_en ? mem[rd_addr[7:0]] : ~rd_data;
    if (wr_en) mem[wr_addr[7:0]] <= wr_data;
  end
endmodule : tmma_mem

// ### tb/tmma_unit_tb_top.sv
// testbench: table searches and mean against an integer model
// assumes tmma_unit with the memory partner on one clock
`timescale 1ns/10ps
module tmma_unit_tb_top;
  import tmma_pkg::*;
  logic              clock = 0, rst = 1, instr_on = 0, result_is_index = 0;
  tmma_op_t          op_sel = TMMA_OP_MAX;
  logic [ADDR_W-1:0] table_start = '0, result_addr = '0, rd_addr, wr_addr;
  logic [LEN_W-1:0]  table_len = 7'h01;
  logic [DATA_W-1:0] rd_data, wr_data;
  logic              rd_en, wr_en, instr_out, busy;
  int                n_mismatch = 0, checks_done = 0, seed = 3;

  always #5 clock = ~clock;

  tmma_unit i_tmma_unit (.clock(clock), .rst(rst), .instr_on(instr_on), .op_sel(op_sel),
    .table_start(table_start), .table_len(table_len), .result_addr(result_addr),
    .result_is_index(result_is_index), .rd_en(rd_en), .rd_addr(rd_addr),
    .rd_data(rd_data), .wr_en(wr_en), .wr_addr(wr_addr), .wr_data(wr_data),
    .instr_out(instr_out), .busy(busy));
  tmma_mem i_tmma_mem (.clock(clock), .rd_en(rd_en), .rd_addr(rd_addr),
    .rd_data(rd_data), .wr_en(wr_en), .wr_addr(wr_addr), .wr_data(wr_data));

  task automatic chk(input logic [DATA_W-1:0] got, input logic [DATA_W-1:0] exp);
    checks_done++;
    if (got !== exp) begin
      n_mismatch++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic print_verdict;
    $display("checks %0d mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : print_verdict

  // bounded wait; a hang ends the run
  task automatic wait_sig(input bit pick_busy, input logic v);
    int k;
    for (k = 0; k < 400 && (pick_busy ? busy : instr_out) !== v; k++) @(negedge clock);
    if ((pick_busy ? busy : instr_out) !== v) begin
      n_mismatch++;
      print_verdict();
    end
  endtask : wait_sig

  // even tests use only extreme words to force ties
  initial begin
    int i, k, n, bi, sum;
    int tbl[$];
    logic [DATA_W-1:0] v, e0, e1;
    repeat (4) @(negedge clock);
    rst = 0;
    for (i = 0; i < 12; i++) begin
      n = (i < 3) ? 64 : (i < 6) ? 1 : 1 + ($unsigned($random(seed)) % 64);
      table_start = 16'(i * 8);
      result_addr = 16'(200 + 2 * i);
      op_sel = tmma_op_t'(i % 3);
      table_len = 7'(n);
      result_is_index = (i % 4 == 1);
      tbl.delete();
      for (k = 0; k < n; k++) begin
        v = (i % 2) ? 16'($random(seed)) : ($random(seed) & 1) ? 16'h8000 : 16'h7FFF;
        i_tmma_mem.mem[i * 8 + k] = v;
        tbl.push_back(int'($signed(v)));
      end
      i_tmma_mem.mem[200 + 2 * i] = 16'hA5A5;
      i_tmma_mem.mem[201 + 2 * i] = 16'h5A5A;
      // strict compare keeps the lowest position on ties
      bi = 0;
      sum = 0;
      for (k = 0; k < n; k++) begin
        sum += tbl[k];
        if (op_sel == TMMA_OP_MAX ? tbl[k] > tbl[bi] : tbl[k] < tbl[bi]) bi = k;
      end
      e0 = (op_sel == TMMA_OP_MEAN) ? 16'(sum / n) : 16'(tbl[bi]);
      e1 = (op_sel == TMMA_OP_MEAN || result_is_index) ? 16'h5A5A : 16'(bi);
      instr_on = 1;
      wait_sig(1'b0, 1'b1);
      instr_on = 0;
      wait_sig(1'b1, 1'b0);
      @(negedge clock);
      chk(i_tmma_mem.mem[200 + 2 * i], e0);
      chk(i_tmma_mem.mem[201 + 2 * i], e1);
      chk({15'h0000, instr_out}, 16'h0000);
      $display("test %0d op %0d len %0d done", i, i % 3, n);
    end
    // input dropped right after the take: the write still lands, output stays off
    result_addr = 16'h00E6;
    i_tmma_mem.mem[230] = 16'hA5A5;
    instr_on = 1;
    @(negedge clock);
    instr_on = 0;
    n = 0;
    for (k = 0; k < 400 && busy === 1'b1; k++) begin
      @(negedge clock);
      n += (instr_out !== 1'b0);
    end
    repeat (2) @(negedge clock);
    n += (instr_out !== 1'b0);
    chk(16'(n), 16'h0000);
    chk({15'h0000, busy}, 16'h0000);
    chk(i_tmma_mem.mem[230], e0);
    $display("test drop done");
    print_verdict();
  end
endmodule : tmma_unit_tb_top
